// ==== design/dbs_pkg.sv ====
// Constants for the draw and copy status classifier
package dbs_pkg;
	// Status word bit positions shared by both views
	localparam int EXC_BIT = 31;
	localparam int CLIP_EXC_BIT = 30;
	localparam int FULL_BIT = 29;
	localparam int BUSY_BIT = 28;
	localparam int BAD_ATTR_BIT = 25;
	localparam int HIRES_BIT = 24;
	localparam int OVERFLOW_BIT = 21;
	localparam int PICK_BIT = 20;
	localparam int CU_FLAGS_LO = 16;
	localparam int COPY_HW_BIT = 15;
	localparam int COPY_SW_BIT = 14;
	localparam int SRC_FLAGS_LO = 11;
	localparam int DST_FLAGS_LO = 8;
	localparam int DRAW_HW_BIT = 4;
	localparam int DRAW_SW_BIT = 3;
	localparam int OBJ_FLAGS_LO = 0;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

	// Raster op attribute fields
	localparam int ROP_SRC_CHK_LO = 0;
	localparam int ROP_NONOVERLAP_BIT = 2;
	localparam logic [31:0] ROP_RESET = 32'h0000_0000;
	localparam logic [1:0] SRC_CHK_INCLUDE = 2'h2;
	localparam logic [1:0] SRC_CHK_EXCLUDE = 2'h1;

	// Signed coordinate window for hardware handling
	localparam int COORD_W = 32;
	localparam logic signed [31:0] RANGE_MIN = -32'sh0000_4000;
	localparam logic signed [31:0] RANGE_MAX = 32'sh0000_3fff;

	// Copy word alignment: bits of pixel shift within a word in eight plane mode
	localparam int ALIGN_W = 2;

	// Indexed load group that filled the vertices
	localparam logic [1:0] LOAD_QUAD = 2'h0;
	localparam logic [1:0] LOAD_TRI = 2'h1;
	localparam logic [1:0] LOAD_LINE = 2'h2;
	localparam logic [1:0] LOAD_POINT = 2'h3;

	// Object kind, one-hot
	localparam logic [3:0] KIND_QUAD = 4'h1;
	localparam logic [3:0] KIND_TRI = 4'h2;
	localparam logic [3:0] KIND_LINE = 4'h4;
	localparam logic [3:0] KIND_POINT = 4'h8;

	// Clip window register selects
	localparam logic [1:0] CLIP_ULX = 2'h0;
	localparam logic [1:0] CLIP_ULY = 2'h1;
	localparam logic [1:0] CLIP_LRX = 2'h2;
	localparam logic [1:0] CLIP_LRY = 2'h3;
endpackage

// ==== design/dbs_classifier.sv ====
// Draw and copy status classification with exception gated start
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE_01: Draw status bit 31 flags draw exception
// RULE_02: Bit 29 full, bit 28 busy, both views
// RULE_03: Bit 20 sticky pick window hit
// RULE_04: Bits 18-16 clip unit hidden/crossing/inside
// RULE_05: Copy hw/sw bits 15/14, src/dst flags
// RULE_06: Draw hw/sw bits 4/3, object flags 2-0
// RULE_07: Raster op attribute selects fill style
// RULE_08: Overlapping fill includes balanced edge lines
// RULE_09: Nonoverlapping drops right/bottom; no lines/points
// RULE_10: Midpoints round right and down
// RULE_11: Quad from four vertices, triangle variants
// RULE_12: Line and point from coincidence or load
// RULE_13: Host copies only in pixel modes
// RULE_14: Copy handles overlap and misalignment
// RULE_15: Host keeps copy corners legal, equal size
// RULE_16: Copy hardware cases from hidden/check select
// RULE_17: Visible/excluded cases need 15-bit signed range
// RULE_18: Recompute status on coordinate or clip write
// RULE_19: Copy exception from five flags
// RULE_20: Copy status read starts copy if clean
// RULE_21: Copy status read-only, regenerated from registers
// RULE_22: Copy exception bit 31, attr 25, hires 24
// RULE_23: Draw exception from six flags
// RULE_24: Draw status read renders if clean
// RULE_25: Copy corners sit in slots 0..3
module dbs_classifier #(
	parameter int CW = dbs_pkg::COORD_W
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic coord_wr,
	input wire logic [1:0] coord_slot,
	input wire logic coord_is_y,
	input wire logic [CW-1:0] coord_wdata,
	input wire logic [1:0] load_kind,
	input wire logic clip_wr,
	input wire logic [1:0] clip_sel,
	input wire logic [CW-1:0] clip_wdata,
	input wire logic rop_wr,
	input wire logic [31:0] rop_wdata,
	input wire logic draw_status_rd,
	input wire logic copy_status_rd,
	input wire logic coord_regs_full,
	input wire logic render_busy,
	input wire logic bad_attribute_flag,
	input wire logic hires_mono_mode,
	input wire logic clip_unit_exception,
	input wire logic clip_unit_hidden,
	input wire logic clip_unit_crossing,
	input wire logic clip_unit_inside,
	input wire logic overflow_event,
	input wire logic pick_event,
	input wire logic overflow_clear,
	input wire logic pick_clear,
	output logic [31:0] draw_object_status,
	output logic [31:0] copy_rect_status,
	output logic [31:0] raster_op_attribute,
	output logic start_draw,
	output logic start_copy,
	output logic [3:0] object_kind,
	output logic rast_fill_balanced,
	output logic rast_skip_right_bottom,
	output logic rast_round_right,
	output logic rast_round_down,
	output logic copy_right_to_left,
	output logic copy_bottom_up,
	output logic [dbs_pkg::ALIGN_W-1:0] copy_align_shift
);

	logic rst_meta;
	logic rst_n;
	logic signed [CW-1:0] vx [4];
	logic signed [CW-1:0] vy [4];
	logic signed [CW-1:0] clip [4];
	logic [1:0] kind_load;
	logic upd_pend;
	logic sticky_overflow;
	logic sticky_pick_hit;
	logic [2:0] next_obj_flags;
	logic [2:0] next_src_flags;
	logic [2:0] next_dst_flags;
	logic next_draw_hw;
	logic next_copy_hw;
	logic [3:0] next_kind;
	logic [31:0] next_common;
	logic draw_exc;
	logic copy_exc;
	logic [1:0] src_chk;
	logic nonoverlap;

	localparam int CLIP_ULX_I = int'(dbs_pkg::CLIP_ULX);
	localparam int CLIP_ULY_I = int'(dbs_pkg::CLIP_ULY);
	localparam int CLIP_LRX_I = int'(dbs_pkg::CLIP_LRX);
	localparam int CLIP_LRY_I = int'(dbs_pkg::CLIP_LRY);

	// Returns {hidden, crossing, inside} of a box against the clip window
	function automatic logic [2:0] clip_test(input logic signed [CW-1:0] xl, input logic signed [CW-1:0] yt,
		input logic signed [CW-1:0] xr, input logic signed [CW-1:0] yb);
		logic hid;
		logic vis;
		hid = (xr < clip[CLIP_ULX_I]) || (xl > clip[CLIP_LRX_I]) || (yb < clip[CLIP_ULY_I]) || (yt > clip[CLIP_LRY_I]);
		vis = (xl >= clip[CLIP_ULX_I]) && (xr <= clip[CLIP_LRX_I]) && (yt >= clip[CLIP_ULY_I]) && (yb <= clip[CLIP_LRY_I]);
		clip_test = {hid, !hid && !vis, vis};
	endfunction

	function automatic logic in_range(input logic signed [CW-1:0] v);
		in_range = (v >= dbs_pkg::RANGE_MIN) && (v <= dbs_pkg::RANGE_MAX);
	endfunction

	function automatic logic signed [CW-1:0] min2(input logic signed [CW-1:0] a, input logic signed [CW-1:0] b);
		min2 = (a < b) ? a : b;
	endfunction

	function automatic logic signed [CW-1:0] max2(input logic signed [CW-1:0] a, input logic signed [CW-1:0] b);
		max2 = (a > b) ? a : b;
	endfunction

	function automatic logic same_vtx(input int a, input int b);
		same_vtx = (vx[a] == vx[b]) && (vy[a] == vy[b]);
	endfunction

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				vx[i] <= '0;
				vy[i] <= '0;
			end
			kind_load <= dbs_pkg::LOAD_QUAD;
		end else if (coord_wr) begin
			if (coord_is_y) begin
				vy[coord_slot] <= coord_wdata;
			end else begin
				vx[coord_slot] <= coord_wdata;
			end
			kind_load <= load_kind;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				clip[i] <= '0;
			end
		end else if (clip_wr) begin
			clip[clip_sel] <= clip_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			raster_op_attribute <= dbs_pkg::ROP_RESET;
		end else if (rop_wr) begin
			raster_op_attribute <= rop_wdata;
		end
	end

	assign src_chk = raster_op_attribute[dbs_pkg::ROP_SRC_CHK_LO +: 2];
	assign nonoverlap = raster_op_attribute[dbs_pkg::ROP_NONOVERLAP_BIT];

	// Set beats clear so an event in the clearing cycle survives
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sticky_overflow <= 1'b0;
			sticky_pick_hit <= 1'b0;
		end else begin
			if (overflow_event) begin
				sticky_overflow <= 1'b1;
			end else if (overflow_clear) begin
				sticky_overflow <= 1'b0;
			end
			if (pick_event) begin
				sticky_pick_hit <= 1'b1; // RULE_03
			end else if (pick_clear) begin
				sticky_pick_hit <= 1'b0;
			end
		end
	end

	// Classification follows one cycle after any geometry write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			upd_pend <= 1'b0;
		end else begin
			upd_pend <= coord_wr || clip_wr || rop_wr; // RULE_18
		end
	end

	// Object shape from vertex coincidence or indexed group
	always_comb begin
		logic e01;
		logic e02;
		logic e03;
		logic e12;
		logic e13;
		logic e23;
		int eqs;
		e01 = same_vtx(0, 1);
		e02 = same_vtx(0, 2);
		e03 = same_vtx(0, 3);
		e12 = same_vtx(1, 2);
		e13 = same_vtx(1, 3);
		e23 = same_vtx(2, 3);
		eqs = int'(e01) + int'(e02) + int'(e03) + int'(e12) + int'(e13) + int'(e23);
		// Six equal pairs: one point; three: three alike; two: two pairs
		if (kind_load == dbs_pkg::LOAD_POINT || eqs == 6) begin
			next_kind = dbs_pkg::KIND_POINT; // RULE_12
		end else if (kind_load == dbs_pkg::LOAD_LINE || eqs == 3 || eqs == 2) begin
			next_kind = dbs_pkg::KIND_LINE; // RULE_12
		end else if (kind_load == dbs_pkg::LOAD_TRI || eqs == 1) begin
			next_kind = dbs_pkg::KIND_TRI; // RULE_11
		end else begin
			next_kind = dbs_pkg::KIND_QUAD; // RULE_11
		end
	end

	always_comb begin
		logic signed [CW-1:0] xmin;
		logic signed [CW-1:0] xmax;
		logic signed [CW-1:0] ymin;
		logic signed [CW-1:0] ymax;
		logic all_range;
		logic surround;
		logic aligned;
		logic end_in;
		logic src_range;
		logic dst_range;
		logic [2:0] ep0;
		logic [2:0] ep1;
		xmin = min2(min2(vx[0], vx[1]), min2(vx[2], vx[3]));
		xmax = max2(max2(vx[0], vx[1]), max2(vx[2], vx[3]));
		ymin = min2(min2(vy[0], vy[1]), min2(vy[2], vy[3]));
		ymax = max2(max2(vy[0], vy[1]), max2(vy[2], vy[3]));
		next_obj_flags = clip_test(xmin, ymin, xmax, ymax);
		all_range = in_range(xmin) && in_range(xmax) && in_range(ymin) && in_range(ymax);
		surround = (xmin <= clip[CLIP_ULX_I]) && (xmax >= clip[CLIP_LRX_I])
			&& (ymin <= clip[CLIP_ULY_I]) && (ymax >= clip[CLIP_LRY_I]);
		aligned = (xmin == xmax) || (ymin == ymax);
		ep0 = clip_test(vx[0], vy[0], vx[0], vy[0]);
		ep1 = clip_test(vx[1], vy[1], vx[1], vy[1]);
		end_in = (next_kind == dbs_pkg::KIND_LINE) && (ep0[0] || ep1[0]);
		next_draw_hw = next_obj_flags[2] || surround
			|| (all_range && (next_obj_flags[0] || end_in || aligned)); // RULE_06
		// Slots 0/1 hold source corners, 2/3 destination corners
		next_src_flags = clip_test(vx[0], vy[0], vx[1], vy[1]); // RULE_25
		next_dst_flags = clip_test(vx[2], vy[2], vx[3], vy[3]); // RULE_25
		src_range = in_range(vx[0]) && in_range(vy[0]) && in_range(vx[1]) && in_range(vy[1]);
		dst_range = in_range(vx[2]) && in_range(vy[2]) && in_range(vx[3]) && in_range(vy[3]);
		next_copy_hw = next_dst_flags[2]
			|| (next_src_flags[2] && src_chk == dbs_pkg::SRC_CHK_INCLUDE)
			|| (next_src_flags[0] && src_chk == dbs_pkg::SRC_CHK_INCLUDE && !next_dst_flags[2]
				&& src_range && dst_range) // RULE_17
			|| (src_chk == dbs_pkg::SRC_CHK_EXCLUDE && !next_dst_flags[2]
				&& src_range && dst_range); // RULE_16
	end

	// Live bits shared by both views
	always_comb begin
		next_common = dbs_pkg::STATUS_RESET;
		next_common[dbs_pkg::CLIP_EXC_BIT] = clip_unit_exception;
		next_common[dbs_pkg::FULL_BIT] = coord_regs_full; // RULE_02
		next_common[dbs_pkg::BUSY_BIT] = render_busy; // RULE_02
		next_common[dbs_pkg::BAD_ATTR_BIT] = bad_attribute_flag; // RULE_22
		next_common[dbs_pkg::HIRES_BIT] = hires_mono_mode; // RULE_22
		next_common[dbs_pkg::OVERFLOW_BIT] = sticky_overflow;
		next_common[dbs_pkg::PICK_BIT] = sticky_pick_hit; // RULE_03
		next_common[dbs_pkg::CU_FLAGS_LO +: 3] = {clip_unit_hidden, clip_unit_crossing, clip_unit_inside}; // RULE_04
	end

	// No write port: both words rebuild from reloaded geometry
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			draw_object_status <= dbs_pkg::STATUS_RESET;
			copy_rect_status <= dbs_pkg::STATUS_RESET;
			object_kind <= dbs_pkg::KIND_QUAD;
		end else begin
			draw_object_status[30:16] <= next_common[30:16];
			copy_rect_status[30:16] <= next_common[30:16]; // RULE_21
			if (upd_pend) begin
				draw_object_status[15:0] <= {next_copy_hw, !next_copy_hw, next_src_flags, next_dst_flags,
					3'h0, next_draw_hw, !next_draw_hw, next_obj_flags}; // RULE_06
				copy_rect_status[15:0] <= {next_copy_hw, !next_copy_hw, next_src_flags, next_dst_flags,
					3'h0, next_draw_hw, !next_draw_hw, next_obj_flags}; // RULE_05
				object_kind <= next_kind;
			end
			draw_object_status[dbs_pkg::EXC_BIT] <= draw_exc; // RULE_01
			copy_rect_status[dbs_pkg::EXC_BIT] <= copy_exc; // RULE_22
		end
	end

	// Exception terms built from the live flags the host will read next and the sw bit of the word held now
	always_comb begin
		draw_exc = draw_object_status[dbs_pkg::DRAW_SW_BIT] || next_common[dbs_pkg::FULL_BIT]
			|| next_common[dbs_pkg::CLIP_EXC_BIT] || next_common[dbs_pkg::BAD_ATTR_BIT]
			|| next_common[dbs_pkg::OVERFLOW_BIT] || next_common[dbs_pkg::CU_FLAGS_LO + 1]; // RULE_23
		copy_exc = copy_rect_status[dbs_pkg::COPY_SW_BIT] || next_common[dbs_pkg::FULL_BIT]
			|| next_common[dbs_pkg::BAD_ATTR_BIT] || next_common[dbs_pkg::OVERFLOW_BIT]
			|| next_common[dbs_pkg::HIRES_BIT]; // RULE_19
	end

	// Starts decided on the word being returned by the read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_draw <= 1'b0;
			start_copy <= 1'b0;
		end else begin
			// Zero-thickness objects are never rendered without edge lines
			start_draw <= draw_status_rd && !draw_object_status[dbs_pkg::EXC_BIT]
				&& !(nonoverlap && (object_kind == dbs_pkg::KIND_LINE
				|| object_kind == dbs_pkg::KIND_POINT)); // RULE_24 RULE_09
			// Hires mono mode forces the exception, so no copy goes out
			start_copy <= copy_status_rd && !copy_rect_status[dbs_pkg::EXC_BIT]; // RULE_20 RULE_13
		end
	end

	// Fill conventions for the span engine
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rast_fill_balanced <= 1'b1;
			rast_skip_right_bottom <= 1'b0;
			rast_round_right <= 1'b0;
			rast_round_down <= 1'b0;
		end else begin
			rast_fill_balanced <= !nonoverlap; // RULE_07 RULE_08
			rast_skip_right_bottom <= nonoverlap; // RULE_09
			rast_round_right <= 1'b1; // RULE_10
			rast_round_down <= 1'b1; // RULE_10
		end
	end

	// Walk direction avoids overwriting unread source on overlap
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			copy_right_to_left <= 1'b0;
			copy_bottom_up <= 1'b0;
			copy_align_shift <= '0;
		end else if (upd_pend) begin
			copy_right_to_left <= vx[2] > vx[0]; // RULE_14
			copy_bottom_up <= vy[2] > vy[0]; // RULE_14
			// Only the low bits matter, so the difference is taken at their width
			copy_align_shift <= vx[2][dbs_pkg::ALIGN_W-1:0] - vx[0][dbs_pkg::ALIGN_W-1:0]; // RULE_14
		end
	end

endmodule

`default_nettype wire

// ==== bench/dbs_props.sv ====
// Port-level assertions for the draw and copy status classifier
`timescale 1ns/10ps
`default_nettype none
module dbs_props (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic coord_regs_full,
	input wire logic render_busy,
	input wire logic clip_unit_hidden,
	input wire logic clip_unit_crossing,
	input wire logic clip_unit_inside,
	input wire logic pick_event,
	input wire logic pick_clear,
	input wire logic draw_status_rd,
	input wire logic copy_status_rd,
	input wire logic [31:0] draw_object_status,
	input wire logic [31:0] copy_rect_status,
	input wire logic [31:0] raster_op_attribute,
	input wire logic [3:0] object_kind,
	input wire logic start_draw,
	input wire logic start_copy
);
	// Outputs trail nrst through the synchroniser; hold off until they track
	logic [2:0] up;
	wire logic nodraw = draw_object_status[31] | raster_op_attribute[2] & object_kind[3:2] != 2'h0;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			up <= 3'h0;
		end else if (up != 3'h7) begin
			up <= up + 3'h1;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst || up != 3'h7);
	property p_full_busy;
		{draw_object_status[29:28], copy_rect_status[29:28]} == {2{$past(coord_regs_full), $past(render_busy)}};
	endproperty
	a_full_busy: assert property (p_full_busy) else $error("full or busy bit wrong");
	property p_pick;
		pick_event ##1 !pick_clear |-> ##1 draw_object_status[20] [*2];
	endproperty
	a_pick: assert property (p_pick) else $error("pick hit not held");
	property p_clip;
		copy_rect_status[18:16] == $past({clip_unit_hidden, clip_unit_crossing, clip_unit_inside});
	endproperty
	a_clip: assert property (p_clip) else $error("clip unit bits wrong");
	property p_views;
		draw_object_status[30:0] == copy_rect_status[30:0];
	endproperty
	a_views: assert property (p_views) else $error("status views differ");
	property p_copy_exc;
		copy_rect_status[31] == (|(copy_rect_status & 32'h2320_0000) || $past(copy_rect_status[14]));
	endproperty
	a_copy_exc: assert property (p_copy_exc) else $error("copy exception wrong");
	property p_draw_exc;
		draw_object_status[31] == (|(draw_object_status & 32'h6222_0000) || $past(draw_object_status[3]));
	endproperty
	a_draw_exc: assert property (p_draw_exc) else $error("draw exception wrong");
	property p_copy_go;
		copy_status_rd |=> start_copy == !$past(copy_rect_status[31]);
	endproperty
	a_copy_go: assert property (p_copy_go) else $error("copy start wrong");
	property p_draw_go;
		draw_status_rd |=> start_draw == !$past(nodraw);
	endproperty
	a_draw_go: assert property (p_draw_go) else $error("draw start wrong");
	property p_no_stray;
		(start_copy |-> $past(copy_status_rd)) and (start_draw |-> $past(draw_status_rd));
	endproperty
	a_no_stray: assert property (p_no_stray) else $error("start without read");
endmodule
bind dbs_classifier dbs_props i_props (.sys_clk, .nrst, .coord_regs_full, .render_busy, .clip_unit_hidden,
	.clip_unit_crossing, .clip_unit_inside, .pick_event, .pick_clear, .draw_status_rd, .copy_status_rd,
	.draw_object_status, .copy_rect_status, .raster_op_attribute, .object_kind, .start_draw, .start_copy);
`default_nettype wire

// ==== bench/dbs_classifier_bench.sv ====
// Self-checking bench for the draw and copy status classifier
`timescale 1ns/10ps
`default_nettype none
module dbs_classifier_bench;
	typedef struct packed {
		logic cp;
		logic st;
		logic [31:0] msk;
		logic [31:0] val;
	} dbs_note_t;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic coord_wr = 1'b0, coord_is_y = 1'b0, clip_wr = 1'b0, rop_wr = 1'b0;
	logic draw_status_rd = 1'b0, copy_status_rd = 1'b0, coord_regs_full = 1'b0, render_busy = 1'b0;
	logic bad_attribute_flag = 1'b0, hires_mono_mode = 1'b0, clip_unit_exception = 1'b0;
	logic clip_unit_hidden = 1'b0, clip_unit_crossing = 1'b0, clip_unit_inside = 1'b0;
	logic overflow_event = 1'b0, pick_event = 1'b0, overflow_clear = 1'b0, pick_clear = 1'b0;
	logic [1:0] coord_slot = 2'h0, load_kind = 2'h0, clip_sel = 2'h0;
	logic [31:0] coord_wdata = 32'h0, clip_wdata = 32'h0, rop_wdata = 32'h0;
	logic [31:0] draw_object_status, copy_rect_status, raster_op_attribute;
	logic start_draw, start_copy, rast_fill_balanced, rast_skip_right_bottom, rast_round_right, rast_round_down;
	logic copy_right_to_left, copy_bottom_up;
	logic [3:0] object_kind;
	logic [1:0] copy_align_shift;
	integer seed = 32'h75aad19f;
	int fail_count = 0;
	int n_compared = 0;
	int v[8];
	int cl[4];
	int wh[2];
	dbs_note_t notes[$];
	dbs_note_t nt;
	logic seen_rd = 1'b0;
	logic seen_cp, dx;
	logic [31:0] seen_w, e;
	logic [4:0] fl;
	logic [7:0] pats[5] = '{8'he4, 8'he0, 8'hc0, 8'h00, 8'ha0};
	logic [3:0] kinds[5] = '{dbs_pkg::KIND_QUAD, dbs_pkg::KIND_TRI, dbs_pkg::KIND_LINE, dbs_pkg::KIND_POINT,
		dbs_pkg::KIND_LINE};
	int bs[4] = '{16380, 16381, -16384, -16385};
	dbs_classifier i_dut (.sys_clk, .nrst, .coord_wr, .coord_slot, .coord_is_y, .coord_wdata, .load_kind,
		.clip_wr, .clip_sel, .clip_wdata, .rop_wr, .rop_wdata, .draw_status_rd, .copy_status_rd,
		.coord_regs_full, .render_busy, .bad_attribute_flag, .hires_mono_mode, .clip_unit_exception,
		.clip_unit_hidden, .clip_unit_crossing, .clip_unit_inside, .overflow_event, .pick_event,
		.overflow_clear, .pick_clear, .draw_object_status, .copy_rect_status, .raster_op_attribute,
		.start_draw, .start_copy, .object_kind, .rast_fill_balanced, .rast_skip_right_bottom,
		.rast_round_right, .rast_round_down, .copy_right_to_left, .copy_bottom_up, .copy_align_shift);
	always #25 sys_clk = ~sys_clk;
	function automatic int rnd(input int n);
		return {$random(seed)} % n;
	endfunction
	// Inclusive clip window; returns hidden, crossing, inside
	function automatic logic [2:0] vis(input int x0, input int y0, input int x1, input int y1);
		if (x1 < cl[0] || x0 > cl[2] || y1 < cl[1] || y0 > cl[3]) return 3'h4;
		if (x0 >= cl[0] && x1 <= cl[2] && y0 >= cl[1] && y1 <= cl[3]) return 3'h1;
		return 3'h2;
	endfunction
	function automatic logic [31:0] cexp(input logic [1:0] ck, input logic xf);
		logic [2:0] s;
		logic [2:0] d;
		logic rng;
		logic hw;
		s = vis(v[0], v[1], v[2], v[3]);
		d = vis(v[4], v[5], v[6], v[7]);
		rng = 1'b1;
		foreach (v[i]) rng &= v[i] >= dbs_pkg::RANGE_MIN && v[i] <= dbs_pkg::RANGE_MAX;
		hw = d[2] || s[2] && ck == dbs_pkg::SRC_CHK_INCLUDE
			|| !d[2] && rng && (s[0] && ck == dbs_pkg::SRC_CHK_INCLUDE || ck == dbs_pkg::SRC_CHK_EXCLUDE);
		return {!hw || xf, 15'h0, hw, !hw, s, d, 8'h0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic poke(input int k, input logic [1:0] sel, input logic y, input logic [31:0] d);
		@(posedge sys_clk);
		coord_wr <= k == 0;
		clip_wr <= k == 1;
		rop_wr <= k == 2;
		coord_slot <= sel;
		clip_sel <= sel;
		coord_is_y <= y;
		coord_wdata <= d;
		clip_wdata <= d;
		rop_wdata <= d;
		@(posedge sys_clk);
		{coord_wr, clip_wr, rop_wr} <= 3'h0;
	endtask
	task automatic load();
		for (int i = 0; i < 4; i++) poke(1, i[1:0], 1'b0, cl[i]);
		for (int i = 0; i < 8; i++) poke(0, i[2:1], i[0], v[i]);
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic rd(input logic cp, input logic st, input logic [31:0] m, input logic [31:0] x);
		notes.push_back('{cp, st, m, x});
		@(posedge sys_clk);
		copy_status_rd <= cp;
		draw_status_rd <= !cp;
		@(posedge sys_clk);
		{copy_status_rd, draw_status_rd} <= 2'h0;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic give_verdict();
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Word is taken in the read cycle, start pulse one cycle later
	always @(negedge sys_clk) begin
		if (seen_rd) begin
			nt = notes.pop_front();
			chk(seen_w & nt.msk, nt.val & nt.msk);
			chk(seen_cp ? start_copy : start_draw, nt.st);
		end
		seen_rd = copy_status_rd | draw_status_rd;
		seen_cp = copy_status_rd;
		seen_w = copy_status_rd ? copy_rect_status : draw_object_status;
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		chk(draw_object_status, dbs_pkg::STATUS_RESET);
		chk(copy_rect_status, dbs_pkg::STATUS_RESET);
		chk(raster_op_attribute, dbs_pkg::ROP_RESET);
		chk({object_kind, rast_fill_balanced}, {dbs_pkg::KIND_QUAD, 1'b1});
		@(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({rast_round_right, rast_round_down}, 2'h3);
		cl = '{0, 0, 100, 100};
		for (int k = 0; k < 10; k++) begin
			for (int i = 0; i < 8; i++) v[i] = 10 + 10 * pats[k / 2][i / 2 * 2 +: 2];
			poke(2, 2'h0, 1'b0, {29'h0, k[0], 2'h2});
			load();
			chk(object_kind, kinds[k / 2]);
			chk({rast_skip_right_bottom, rast_fill_balanced}, {k[0], !k[0]});
			rd(1'b0, !(k[0] && kinds[k / 2] > 4'h2), 32'h8000001f, 32'h11);
		end
		$display("object kind test done");
		v = '{10, 10, 20, 20, 30, 30, 40, 40};
		for (int k = 1; k < 4; k++) begin
			load_kind <= 2'(k);
			load();
			chk(object_kind, kinds[k]);
		end
		load_kind <= 2'h0;
		poke(2, 2'h0, 1'b0, 32'h2);
		load();
		for (int f = 0; f < 7; f++) begin
			fl = 5'h1 << f;
			{coord_regs_full, bad_attribute_flag, hires_mono_mode, clip_unit_exception, clip_unit_crossing} <= fl;
			{overflow_event, pick_event} <= {2{f == 5}};
			{overflow_clear, pick_clear} <= {2{f == 6}};
			@(posedge sys_clk);
			{overflow_event, pick_event, overflow_clear, pick_clear} <= 4'h0;
			repeat (4) @(posedge sys_clk);
			e = cexp(2'h2, fl[4:2] != 3'h0 || f == 5);
			rd(1'b1, !e[31], 32'h8000ff00, e);
			dx = fl[4] | fl[3] | fl[1] | fl[0] | f == 5;
			rd(1'b0, !dx, 32'h8000001f, {dx, 26'h0, 5'h11});
		end
		$display("exception test done");
		cl = '{-20000, -20000, 20000, 20000};
		poke(2, 2'h0, 1'b0, 32'h1);
		for (int j = 0; j < 4; j++) begin
			v = '{bs[j], 10, bs[j] + 3, 13, 10, 20, 13, 23};
			load();
			e = cexp(2'h1, 1'b0);
			rd(1'b1, !e[31], 32'h8000ff00, e);
		end
		$display("range test done");
		for (int t = 0; t < 24; t++) begin
			e[2:0] = 3'(rnd(8));
			poke(2, 2'h0, 1'b0, {29'h0, e[2:0]});
			for (int i = 0; i < 2; i++) begin
				cl[i] = rnd(200);
				cl[i + 2] = cl[i] + rnd(300);
				wh[i] = rnd(100);
			end
			for (int i = 0; i < 8; i++) v[i] = i % 4 < 2 ? rnd(400) : v[i - 2] + wh[i % 2];
			{render_busy, clip_unit_hidden, clip_unit_inside} <= 3'(rnd(8));
			load();
			chk({rast_skip_right_bottom, rast_fill_balanced}, {e[2], !e[2]});
			chk(raster_op_attribute, {29'h0, e[2:0]});
			chk({copy_right_to_left, copy_bottom_up, copy_align_shift}, {v[4] > v[0], v[5] > v[1], 2'(v[4] - v[0])});
			e = cexp(e[1:0], 1'b0);
			rd(1'b1, !e[31], 32'h8000ff00, e);
		end
		$display("random copy test done");
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
